// [omc_pkg.sv]
package omc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NSEG = 5;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_PRIMARY_CTRL = 8'h00;
  localparam logic [7:0] OFS_PAGE_DIR_BASE = 8'h04;
  localparam logic [7:0] OFS_EXT_FEATURE = 8'h08;
  localparam logic [7:0] OFS_FEATURE_CTRL = 8'h0c;
  localparam logic [7:0] OFS_CODE_SEG_LOAD = 8'h10;
  localparam logic [7:0] OFS_SEG_LOAD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_PE = 0;
  localparam int BIT_PG = 31;
  localparam int BIT_LME = 8;
  localparam int BIT_LMA = 10;
  localparam int BIT_PAE = 5;
  localparam int BIT_CS_L = 0;
  localparam int BIT_CS_D = 1;
  localparam int POS_CS_RPL = 2;
  localparam int POS_SEG_NULL = 0;
  localparam int POS_SEG_REAL = 8;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RST_PAGE_DIR_BASE = 32'h0000_0000;
  localparam logic [1:0] RST_CPL = 2'h0;
  typedef enum {MODE_REAL, MODE_PROT, MODE_COMPAT, MODE_64} omc_mode_e;
  typedef enum {SZ_16, SZ_32, SZ_64} omc_size_e;
endpackage

// [omc_check.sv]
`timescale 1ns/10ps
module omc_check
  import omc_pkg::*;
(
  input wire logic i_wr_primary,
  input wire logic i_wr_ext,
  input wire logic i_wr_feat,
  input wire logic [31:0] i_wdata,
  input wire logic i_pe,
  input wire logic i_pg,
  input wire logic i_lme,
  input wire logic i_lma,
  input wire logic i_pae,
  input wire logic i_cs_l,
  output logic o_fault
);
  wire pg_rise = i_wr_primary && i_wdata[BIT_PG] && !i_pg;
  // Paging needs protection, and extended mode needs the address extension
  wire bad_primary = pg_rise && (!i_wdata[BIT_PE] || (i_lme && (!i_pae || i_cs_l)));
  // Enable bit may only move while paging is off
  wire bad_ext = i_wr_ext && (i_wdata[BIT_LME] != i_lme) && i_pg;
  wire bad_feat = i_wr_feat && !i_wdata[BIT_PAE] && i_lma;
  assign o_fault = bad_primary || bad_ext || bad_feat;
endmodule

// [omc_decode.sv]
`timescale 1ns/10ps
module omc_decode
  import omc_pkg::*;
(
  input wire logic i_pe,
  input wire logic i_lma,
  input wire logic i_cs_l,
  input wire logic i_cs_d,
  input wire logic i_pfx_op64,
  input wire logic i_pfx_op16,
  input wire logic i_pfx_ad32,
  output omc_mode_e o_mode,
  output omc_size_e o_def_op,
  output omc_size_e o_def_addr,
  output omc_size_e o_eff_op,
  output omc_size_e o_eff_addr,
  output logic o_reserved
);
  function automatic omc_size_e flip(input omc_size_e s, input logic p);
    flip = !p ? s : (s == SZ_16) ? SZ_32 : SZ_16;
  endfunction
  wire is64 = i_lma && i_cs_l && !i_cs_d;
  wire legacy_d = i_pe && i_cs_d;
  assign o_reserved = i_lma && i_cs_l && i_cs_d;
  assign o_mode = !i_pe ? MODE_REAL : is64 ? MODE_64 :
                  i_lma ? MODE_COMPAT : MODE_PROT;
  assign o_def_op = (is64 || legacy_d) ? SZ_32 : SZ_16;
  assign o_def_addr = is64 ? SZ_64 : legacy_d ? SZ_32 : SZ_16;
  assign o_eff_op = !is64 ? flip(o_def_op, i_pfx_op16) :
                    i_pfx_op64 ? SZ_64 : i_pfx_op16 ? SZ_16 : SZ_32;
  assign o_eff_addr = !is64 ? flip(o_def_addr, i_pfx_ad32) :
                      i_pfx_ad32 ? SZ_32 : SZ_64;
endmodule

// [omc_top.sv]
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module omc_top
  import omc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_pfx_op64,
  input wire logic i_pfx_op16,
  input wire logic i_pfx_ad32,
  output logic [DATA_W-1:0] o_rdata,
  output omc_mode_e o_mode,
  output omc_size_e o_def_op,
  output omc_size_e o_def_addr,
  output omc_size_e o_eff_op,
  output omc_size_e o_eff_addr,
  output logic o_cs_reserved,
  output logic [1:0] o_cpl,
  output logic o_four_level_xlate,
  output logic o_ext_delivery,
  output logic o_gp_fault,
  output logic o_tlb_flush,
  output logic o_serialize,
  output logic o_queue_flush,
  output logic o_upper_regs_clear,
  output logic [NSEG-1:0] o_seg_unusable,
  output logic [NSEG-1:0] o_seg_cached_attr
);
  // ****************************************
  // Architectural state
  // ****************************************
  logic pe_r;
  logic pg_r;
  logic lme_r;
  logic lma_r;
  logic pae_r;
  logic [31:0] pdbr_r;
  logic cs_l_r;
  logic cs_d_r;
  logic [1:0] cpl_r;
  logic pe_pend_r;
  logic real_pend_r;
  logic used64_r;
  logic lost_r;
  logic [NSEG-1:0] seg_null_r;
  logic [NSEG-1:0] seg_real_r;
  logic gp_r;
  logic tlb_r;
  logic ser_r;
  logic qflush_r;
  logic uclr_r;
  logic [DATA_W-1:0] rdata_r;
  omc_mode_e mode_r;
  omc_size_e def_op_r;
  omc_size_e def_addr_r;
  omc_size_e eff_op_r;
  omc_size_e eff_addr_r;
  logic rsvd_r;
  // ****************************************
  // Address decode
  // ****************************************
  wire wr_primary = i_wr && (i_addr == OFS_PRIMARY_CTRL);
  wire wr_pdbr = i_wr && (i_addr == OFS_PAGE_DIR_BASE);
  wire wr_ext = i_wr && (i_addr == OFS_EXT_FEATURE);
  wire wr_feat = i_wr && (i_addr == OFS_FEATURE_CTRL);
  wire wr_cs = i_wr && (i_addr == OFS_CODE_SEG_LOAD);
  wire wr_seg = i_wr && (i_addr == OFS_SEG_LOAD);
  wire fault;
  wire primary_ok = wr_primary && !fault;
  wire new_pe = i_wdata[BIT_PE];
  wire new_pg = i_wdata[BIT_PG];
  wire pe_set = primary_ok && new_pe && !pe_r;
  wire pe_clr = primary_ok && !new_pe && pe_r;
  wire pg_on = primary_ok && new_pg && !pg_r;
  wire pg_off = primary_ok && !new_pg && pg_r;
  // Far branch into real mode whenever protection is off
  wire cs_to_real = wr_cs && (real_pend_r || !pe_r);
  wire new_l = wr_cs && !cs_to_real && i_wdata[BIT_CS_L];
  wire new_d = wr_cs && !cs_to_real && i_wdata[BIT_CS_D];
  wire enter64 = wr_cs && lma_r && new_l && !new_d;
  omc_mode_e dec_mode;
  omc_size_e dec_op;
  omc_size_e dec_addr;
  omc_size_e dec_eop;
  omc_size_e dec_eaddr;
  wire dec_rsvd;
  omc_check u_check (
    .i_wr_primary(wr_primary),
    .i_wr_ext(wr_ext),
    .i_wr_feat(wr_feat),
    .i_wdata(i_wdata),
    .i_pe(pe_r),
    .i_pg(pg_r),
    .i_lme(lme_r),
    .i_lma(lma_r),
    .i_pae(pae_r),
    .i_cs_l(cs_l_r),
    .o_fault(fault)
  );
  omc_decode u_decode (
    .i_pe(pe_r),
    .i_lma(lma_r),
    .i_cs_l(cs_l_r),
    .i_cs_d(cs_d_r),
    .i_pfx_op64(i_pfx_op64),
    .i_pfx_op16(i_pfx_op16),
    .i_pfx_ad32(i_pfx_ad32),
    .o_mode(dec_mode),
    .o_def_op(dec_op),
    .o_def_addr(dec_addr),
    .o_eff_op(dec_eop),
    .o_eff_addr(dec_eaddr),
    .o_reserved(dec_rsvd)
  );
  wire [DATA_W-1:0] status_word = {21'h0, pe_pend_r, lost_r, cpl_r, rsvd_r,
                                   2'(def_addr_r), 2'(def_op_r), 2'(mode_r)};
  wire [DATA_W-1:0] rd_mux =
    (i_addr == OFS_PRIMARY_CTRL) ? {pg_r, 30'h0, pe_r} :
    (i_addr == OFS_PAGE_DIR_BASE) ? pdbr_r :
    (i_addr == OFS_EXT_FEATURE) ? (32'(lme_r) << BIT_LME) | (32'(lma_r) << BIT_LMA) :
    (i_addr == OFS_FEATURE_CTRL) ? 32'(pae_r) << BIT_PAE :
    (i_addr == OFS_CODE_SEG_LOAD) ? {28'h0, cpl_r, cs_d_r, cs_l_r} :
    (i_addr == OFS_SEG_LOAD) ? {19'h0, seg_real_r, 3'h0, seg_null_r} :
    (i_addr == OFS_STATUS) ? status_word : 32'h0;
  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pe_r <= 1'b0;
      pg_r <= 1'b0;
      lme_r <= 1'b0;
      pae_r <= 1'b0;
      pdbr_r <= RST_PAGE_DIR_BASE;
    end else begin
      if (primary_ok) begin
        pe_r <= new_pe;
        pg_r <= new_pg;
      end
      if (wr_ext && !fault) lme_r <= i_wdata[BIT_LME];
      if (wr_feat && !fault) pae_r <= i_wdata[BIT_PAE];
      if (wr_pdbr) pdbr_r <= i_wdata;
    end
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      lma_r <= 1'b0;
    end else if (pg_on && lme_r) begin
      lma_r <= 1'b1;
    end else if (pg_off) begin
      lma_r <= 1'b0;
    end
  end
  // ****************************************
  // Code segment and privilege
  // ****************************************
  // Protection write leaves the code segment alone until the far branch
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_l_r <= 1'b0;
      cs_d_r <= 1'b0;
      cpl_r <= RST_CPL;
      pe_pend_r <= 1'b0;
      real_pend_r <= 1'b0;
    end else begin
      if (wr_cs) begin
        cs_l_r <= new_l;
        cs_d_r <= new_d;
        cpl_r <= cs_to_real ? RST_CPL : i_wdata[POS_CS_RPL +: 2];
        pe_pend_r <= 1'b0;
        real_pend_r <= 1'b0;
      end
      // A stale pending flag would misroute the next far branch
      if (pe_set) begin
        cpl_r <= RST_CPL;
        pe_pend_r <= 1'b1;
        real_pend_r <= 1'b0;
      end
      if (pe_clr) begin
        real_pend_r <= 1'b1;
        pe_pend_r <= 1'b0;
      end
    end
  end
  // ****************************************
  // Upper register tracking and segment cache
  // ****************************************
  // Compat round trips keep upper regs; a legacy visit loses them
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      used64_r <= 1'b0;
      lost_r <= 1'b0;
      seg_null_r <= '0;
      seg_real_r <= '0;
    end else begin
      if (enter64) begin
        used64_r <= 1'b1;
        lost_r <= 1'b0;
      end else if (pg_off && lma_r && used64_r) begin
        lost_r <= 1'b1;
      end
      if (wr_seg) begin
        seg_null_r <= i_wdata[POS_SEG_NULL +: NSEG];
        seg_real_r <= i_wdata[POS_SEG_REAL +: NSEG];
      end else if (pe_set) begin
        seg_real_r <= '0;
      end
    end
  end
  // ****************************************
  // Event pulses, decoded outputs, read data
  // ****************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      gp_r <= 1'b0;
      tlb_r <= 1'b0;
      ser_r <= 1'b0;
      qflush_r <= 1'b0;
      uclr_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      gp_r <= fault;
      tlb_r <= wr_pdbr && (i_wdata == 32'h0);
      ser_r <= wr_cs && pe_pend_r;
      qflush_r <= cs_to_real;
      uclr_r <= enter64 && lost_r;
      rdata_r <= i_rd ? rd_mux : '0;
    end
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_r <= MODE_REAL;
      def_op_r <= SZ_16;
      def_addr_r <= SZ_16;
      eff_op_r <= SZ_16;
      eff_addr_r <= SZ_16;
      rsvd_r <= 1'b0;
    end else begin
      mode_r <= dec_mode;
      def_op_r <= dec_op;
      def_addr_r <= dec_addr;
      eff_op_r <= dec_eop;
      eff_addr_r <= dec_eaddr;
      rsvd_r <= dec_rsvd;
    end
  end
  assign o_rdata = rdata_r;
  assign o_mode = mode_r;
  assign o_def_op = def_op_r;
  assign o_def_addr = def_addr_r;
  assign o_eff_op = eff_op_r;
  assign o_eff_addr = eff_addr_r;
  assign o_cs_reserved = rsvd_r;
  assign o_cpl = cpl_r;
  assign o_four_level_xlate = lma_r;
  assign o_ext_delivery = lma_r;
  assign o_gp_fault = gp_r;
  assign o_tlb_flush = tlb_r;
  assign o_serialize = ser_r;
  assign o_queue_flush = qflush_r;
  assign o_upper_regs_clear = uclr_r;
  // In real mode, null selectors are unusable and non-reloaded ones run on cached attributes; both are 0 in other modes
  assign o_seg_unusable = (mode_r == MODE_REAL) ? seg_null_r : '0;
  assign o_seg_cached_attr = (mode_r == MODE_REAL) ? ~seg_real_r : '0;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  property p_lma_clear;
    pg_off && lma_r |=> !lma_r && !o_four_level_xlate;
  endproperty
  a_lma_clear: assert property (p_lma_clear) else $error("active bit kept");
  property p_lma_set;
    pg_on && lme_r |=> lma_r && o_ext_delivery;
  endproperty
  a_lma_set: assert property (p_lma_set) else $error("active bit not set");
  property p_fault_ext;
    wr_ext && pg_r && (i_wdata[BIT_LME] != lme_r) |=> o_gp_fault && $stable(lme_r);
  endproperty
  a_fault_ext: assert property (p_fault_ext) else $error("enable moved with paging");
  property p_tlb;
    wr_pdbr && (i_wdata == 32'h0) |=> o_tlb_flush ##1 !o_tlb_flush || wr_pdbr;
  endproperty
  a_tlb: assert property (p_tlb) else $error("no translation flush");
  property p_serialize;
    pe_set ##1 (wr_cs && !pe_clr) |=> o_serialize;
  endproperty
  a_serialize: assert property (p_serialize) else $error("no serialize");
  property p_real_jump;
    wr_cs && real_pend_r |=> o_queue_flush && !cs_l_r && !cs_d_r;
  endproperty
  a_real_jump: assert property (p_real_jump) else $error("real jump wrong");
  property p_cpl0;
    pe_set |=> o_cpl == RST_CPL && pe_r;
  endproperty
  a_cpl0: assert property (p_cpl0) else $error("privilege not zero");
  property p_mode64;
    o_mode == MODE_64 |-> o_def_op == SZ_32 && o_def_addr == SZ_64 && lma_r;
  endproperty
  a_mode64: assert property (p_mode64) else $error("64-bit sizes wrong");
  property p_compat;
    pe_r && lma_r && !cs_l_r && !wr_cs && !primary_ok |=>
      o_mode == MODE_COMPAT && o_def_op == (cs_d_r ? SZ_32 : SZ_16);
  endproperty
  a_compat: assert property (p_compat) else $error("compat sizes wrong");
  property p_to_real;
    pe_clr |=> !pe_r ##1 o_mode == MODE_REAL;
  endproperty
  a_to_real: assert property (p_to_real) else $error("real mode not reached");
  property p_cs_kept;
    pe_set && !wr_cs |=> $stable(cs_l_r) && $stable(cs_d_r);
  endproperty
  a_cs_kept: assert property (p_cs_kept) else $error("code segment changed");
  // Upper register fate on each 64-bit entry
  property p_upper_keep;
    enter64 && !lost_r |=> !o_upper_regs_clear;
  endproperty
  a_upper_keep: assert property (p_upper_keep) else $error("upper regs dropped");
  property p_upper_lost;
    enter64 && lost_r |=> o_upper_regs_clear;
  endproperty
  a_upper_lost: assert property (p_upper_lost) else $error("upper loss not flagged");
  property p_fault_pg;
    wr_primary && i_wdata[BIT_PG] && !i_wdata[BIT_PE] && !pg_r |=> o_gp_fault && !pg_r;
  endproperty
  a_fault_pg: assert property (p_fault_pg) else $error("paging without protection");
  property p_rsvd;
    lma_r && cs_l_r && cs_d_r |=> o_cs_reserved;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved segment missed");
  property p_eff64;
    pe_r && lma_r && cs_l_r && !cs_d_r && i_pfx_op64 |=> o_eff_op == SZ_64;
  endproperty
  a_eff64: assert property (p_eff64) else $error("operand prefix ignored");
  property p_tlb_keep;
    wr_pdbr && (i_wdata != 32'h0) |=> !o_tlb_flush;
  endproperty
  a_tlb_keep: assert property (p_tlb_keep) else $error("spurious translation flush");
  c_upper_kept: cover property (enter64 && used64_r && !lost_r);
  c_enter_prot: cover property (pe_set ##[1:4] o_serialize);
  c_enter_long: cover property (pg_on && lme_r ##[1:20] o_mode == MODE_64);
  c_back_real: cover property (pe_clr ##[1:8] o_queue_flush);
  c_upper_lost: cover property (o_upper_regs_clear);
endmodule

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top
  import omc_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_resetn;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic i_wr, i_rd, i_pfx_op64, i_pfx_op16, i_pfx_ad32;
  omc_mode_e o_mode;
  omc_size_e o_def_op, o_def_addr, o_eff_op, o_eff_addr;
  logic o_cs_reserved, o_four_level_xlate, o_ext_delivery, o_gp_fault, o_tlb_flush;
  logic o_serialize, o_queue_flush, o_upper_regs_clear;
  logic [1:0] o_cpl;
  logic [NSEG-1:0] o_seg_unusable, o_seg_cached_attr;
  int failures, n_tests;
  int prot, pgon, lmen, lmact, paex, csl, csd, pend;
  logic [31:0] rv, nm;
  logic [1:0] tbl [4] = '{2'b00, 2'b10, 2'b11, 2'b01};

  omc_top u_omc_top (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_pfx_op64(i_pfx_op64),
    .i_pfx_op16(i_pfx_op16), .i_pfx_ad32(i_pfx_ad32), .o_rdata(o_rdata), .o_mode(o_mode),
    .o_def_op(o_def_op), .o_def_addr(o_def_addr), .o_eff_op(o_eff_op),
    .o_eff_addr(o_eff_addr), .o_cs_reserved(o_cs_reserved), .o_cpl(o_cpl),
    .o_four_level_xlate(o_four_level_xlate), .o_ext_delivery(o_ext_delivery),
    .o_gp_fault(o_gp_fault), .o_tlb_flush(o_tlb_flush), .o_serialize(o_serialize),
    .o_queue_flush(o_queue_flush), .o_upper_regs_clear(o_upper_regs_clear),
    .o_seg_unusable(o_seg_unusable), .o_seg_cached_attr(o_seg_cached_attr));

  always #20 i_clock = ~i_clock;

  // ****************************************
  // Reference model and bus tasks
  // ****************************************
  function automatic logic [31:0] emode();
    if (!prot) return MODE_REAL;
    if (!lmact) return MODE_PROT;
    return csl ? MODE_64 : MODE_COMPAT;
  endfunction

  function automatic logic [31:0] esz(input bit adr);
    if (lmact && csl && !csd) return adr ? SZ_64 : SZ_32;
    return csd ? SZ_32 : SZ_16;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Model state moves first, so the checks below see the expected outcome
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic f, ser, qf;
    f = 1'b0;
    ser = 1'b0;
    qf = 1'b0;
    case (a)
      OFS_PRIMARY_CTRL: begin
        f = d[31] && !pgon && (!d[0] || (lmen && (!paex || csl)));
        if (!f) begin
          if (d[0] && !prot) pend = 1;
          if (!d[0] && prot) pend = 0;
          if (d[31] && !pgon && lmen) lmact = 1;
          if (!d[31] && pgon) lmact = 0;
          prot = d[0];
          pgon = d[31];
        end
      end
      OFS_EXT_FEATURE: begin
        f = (d[8] != lmen[0]) && pgon;
        if (!f) lmen = d[8];
      end
      OFS_FEATURE_CTRL: begin
        f = !d[5] && lmact;
        if (!f) paex = d[5];
      end
      OFS_CODE_SEG_LOAD: begin
        ser = pend;
        pend = 0;
        qf = !prot;
        csl = prot ? d[0] : 0;
        csd = prot ? d[1] : 0;
      end
      default: ;
    endcase
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
    chk(o_gp_fault, f);
    chk(o_tlb_flush, a == OFS_PAGE_DIR_BASE && d == 0);
    chk(o_serialize, ser);
    chk(o_queue_flush, qf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask

  // Reserved code segment leaves mode and sizes open, so only the flag and the lmact outputs count
  task automatic st();
    repeat (2) @(posedge i_clock);
    #1;
    if (!(lmact && csl && csd)) begin
      chk(o_mode, emode());
      chk(o_def_op, esz(0));
      chk(o_def_addr, esz(1));
    end
    chk(o_four_level_xlate, lmact);
    chk(o_ext_delivery, lmact);
    chk(o_cs_reserved, lmact && csl && csd);
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (5000) @(posedge i_clock);
    failures++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_resetn, i_wr, i_rd, i_pfx_op64, i_pfx_op16, i_pfx_ad32} = '0;
    i_addr = '0;
    i_wdata = '0;
    {failures, n_tests, prot, pgon, lmen, lmact, paex, csl, csd, pend} = '0;
    rv = $urandom(32'hded9);
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    #1;
    chk(o_mode, MODE_REAL);
    chk(o_cpl, 2'h0);
    wr(8'hfc, 32'hffff_ffff);
    rd(8'hfc, 32'h0);
    $display("test reset done");
    wr(OFS_PRIMARY_CTRL, 32'h8000_0000);
    wr(OFS_PRIMARY_CTRL, 32'h0000_0001);
    st();
    chk(o_cpl, 2'h0);
    wr(OFS_CODE_SEG_LOAD, 32'h0);
    st();
    $display("test protected entry done");
    wr(OFS_FEATURE_CTRL, 32'h0000_0020);
    wr(OFS_EXT_FEATURE, 32'h0000_0100);
    wr(OFS_PRIMARY_CTRL, 32'h8000_0001);
    rd(OFS_EXT_FEATURE, 32'h0000_0500);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CODE_SEG_LOAD, {30'h0, tbl[k]});
      chk(o_upper_regs_clear, 1'b0);
      st();
    end
    for (int p = 0; p < 4; p++) begin
      @(posedge i_clock);
      i_pfx_op64 <= (p == 1);
      i_pfx_op16 <= (p == 2);
      i_pfx_ad32 <= (p == 3);
      repeat (2) @(posedge i_clock);
      #1;
      chk(o_eff_op, p == 1 ? SZ_64 : p == 2 ? SZ_16 : SZ_32);
      chk(o_eff_addr, p == 3 ? SZ_32 : SZ_64);
    end
    @(posedge i_clock);
    {i_pfx_op64, i_pfx_op16, i_pfx_ad32} <= 3'b000;
    $display("test extended modes done");
    wr(OFS_EXT_FEATURE, 32'h0);
    wr(OFS_FEATURE_CTRL, 32'h0);
    rd(OFS_EXT_FEATURE, 32'h0000_0500);
    wr(OFS_CODE_SEG_LOAD, 32'h0);
    wr(OFS_CODE_SEG_LOAD, 32'h1);
    chk(o_upper_regs_clear, 1'b0);
    wr(OFS_CODE_SEG_LOAD, 32'h0);
    wr(OFS_PRIMARY_CTRL, 32'h0000_0001);
    rd(OFS_EXT_FEATURE, 32'h0000_0100);
    st();
    wr(OFS_PAGE_DIR_BASE, 32'h0);
    rv = $urandom | 32'h1;
    wr(OFS_PAGE_DIR_BASE, rv);
    rd(OFS_PAGE_DIR_BASE, rv);
    wr(OFS_EXT_FEATURE, 32'h0);
    wr(OFS_PRIMARY_CTRL, 32'h8000_0001);
    rd(OFS_EXT_FEATURE, 32'h0);
    wr(OFS_CODE_SEG_LOAD, 32'h0);
    wr(OFS_PRIMARY_CTRL, 32'h0000_0001);
    wr(OFS_EXT_FEATURE, 32'h0000_0100);
    wr(OFS_PRIMARY_CTRL, 32'h8000_0001);
    wr(OFS_CODE_SEG_LOAD, 32'h1);
    chk(o_upper_regs_clear, 1'b1);
    wr(OFS_CODE_SEG_LOAD, 32'h0);
    wr(OFS_PRIMARY_CTRL, 32'h0000_0001);
    wr(OFS_EXT_FEATURE, 32'h0);
    $display("test extended exit done");
    nm = $urandom & 32'h1f;
    wr(OFS_SEG_LOAD, ((~nm & 32'h1f) << 8) | nm);
    wr(OFS_PRIMARY_CTRL, 32'h0);
    wr(OFS_CODE_SEG_LOAD, 32'h0);
    st();
    chk(o_seg_unusable, nm);
    rv = $urandom & 32'h1f;
    wr(OFS_SEG_LOAD, rv << 8);
    repeat (2) @(posedge i_clock);
    #1;
    chk(o_seg_cached_attr, ~rv & 32'h1f);
    $display("test real return done");
    summarize();
  end
endmodule
